// >>> bench/mscl_chk.sv
// Purpose: Assertions on the ports of mscl_core
// Assumes: Rates at 08 to 14, control at 18
// Notes:   Mirrors rate writes so stop rates have an exact figure
`timescale 1ns/1ns
`include "mscl_defs.svh"
module mscl_chk (
	// Clock, reset and bus
	input wire logic                   REF_CLK,
	input wire logic                   RST,
	input wire logic                   PSEL,
	input wire logic                   PENABLE,
	input wire logic                   PWRITE,
	input wire logic [7:0]             PADDR,
	input wire logic [31:0]            PWDATA,
	// Motion and outputs
	input wire mscl_pkg::mscl_motion_t MOTION,
	input wire mscl_pkg::mscl_stop_t   STOP,
	input wire logic                   POS_LOAD,
	input wire logic [31:0]            POS_VALUE,
	input wire logic [7:0]             GP_OUT,
	input wire logic                   TX_VALID,
	input wire logic [7:0]             TX_DATA,
	input wire logic                   TX_READY
);
	logic [15:0] rt [8];
	logic        mt;
	logic        hd;
	wire         wr  = PSEL && PENABLE && PWRITE;
	wire         wc  = wr && PADDR == `MSCL_ADDR_CMD;
	wire         fl  = wc && PWDATA[3:0] == `MSCL_OP_STOP_FLUSH;
	wire         sj  = wc && PWDATA[3:0] == `MSCL_OP_STOP_JOG;
	wire         imm = fl || sj;
	wire         run = mt && MOTION.busy;
	wire  [15:0] frt = PWDATA[5:4] != 2'h1 ? rt[4] :
		MOTION.kind == 2'h1 ? rt[2] : rt[5];
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rt <= '{default: 16'h0064};
			mt <= 1'b0;
			hd <= 1'b0;
		end else if (wr) begin
			if (PADDR >= 8'h08 && PADDR <= 8'h14)
				rt[PADDR[4:2]] <= PWDATA[15:0];
			if (PADDR == 8'h18) begin
				mt <= PWDATA[0];
				hd <= PWDATA[1];
			end
		end
	end
	a_jog_stop:
		assert property (sj && MOTION.busy && MOTION.kind == 2'h1
			|=> STOP.req && STOP.rate == rt[2]) else $error("jog stop");
	a_flush_req:
		assert property (fl |=> STOP.req == $past(MOTION.busy)
			&& STOP.abort_wait == $past(MOTION.waiting))
			else $error("flush stop");
	a_flush_rate:
		assert property (fl && MOTION.busy |=> STOP.rate == $past(frt))
			else $error("flush rate");
	a_abort_src:
		assert property (STOP.abort_wait |-> $past(fl))
			else $error("wait aborted");
	a_queued_stop:
		assert property (STOP.req && !$past(imm) |-> $past(run)
			&& $past(MOTION.kind) != 2'h2) else $error("queued stop");
	a_out_step:
		assert property ($onehot0(GP_OUT ^ $past(GP_OUT)))
			else $error("outputs jumped");
	a_pos_hold:
		assert property (!POS_LOAD |-> $stable(POS_VALUE))
			else $error("position moved");
	a_tx_hold:
		assert property (TX_VALID && !TX_READY && !fl
			|=> TX_VALID && $stable(TX_DATA)) else $error("tx dropped");
	a_hd_quiet:
		assert property (hd && !TX_VALID |=> !TX_VALID)
			else $error("tx on half duplex");
endmodule
bind mscl_core mscl_chk i_chk (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .MOTION, .STOP, .POS_LOAD, .POS_VALUE, .GP_OUT,
	.TX_VALID, .TX_DATA, .TX_READY);

// >>> bench/mscl_motion_model.sv
// Purpose: Motion unit and serial receiver beside mscl_core
// Assumes: A move runs 40 cycles, a stop ends it in 3
// Notes:   Ready toggles unless fast, so the byte stream stalls
`timescale 1ns/1ns
module mscl_motion_model (
	// Clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RST,
	// Design side
	input  wire mscl_pkg::mscl_stop_t   STOP,
	input  wire mscl_pkg::mscl_move_t   MOVE,
	input  wire logic                   TX_VALID,
	input  wire logic [7:0]             TX_DATA,
	output mscl_pkg::mscl_motion_t      MOTION,
	output logic                        TX_READY,
	// Bench side
	input  wire logic                   wt_go,
	input  wire logic                   fast,
	output logic      [31:0]            rx
);
	logic [7:0] cnt;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			MOTION <= '0;
			cnt <= '0;
			TX_READY <= 1'b0;
			rx <= '0;
		end else begin
			TX_READY <= fast | ~TX_READY;
			if (TX_VALID && TX_READY)
				rx <= {TX_DATA, rx[31:8]};
			if (wt_go)
				MOTION.waiting <= 1'b1;
			else if (STOP.abort_wait)
				MOTION.waiting <= 1'b0;
			MOTION.busy <= MOVE.start || cnt > 8'h01;
			if (MOVE.start) begin
				MOTION.kind <= MOVE.kind;
				cnt <= 8'h28;
			end else if (STOP.req && cnt > 8'h03)
				cnt <= 8'h03;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule

// >>> bench/test_motion_stop_command_logic.sv
// Purpose: Self-checking bench for mscl_core
// Assumes: Rates written as 11, 22, 33, 44 to tell sources apart
// Notes:   Stop cases run from a table, the rest by hand
`timescale 1ns/1ns
module test_motion_stop_command_logic;
	typedef struct packed {
		logic        mt;
		logic [3:0]  mv;
		logic [3:0]  st;
		logic [1:0]  prm;
		logic        req;
		logic [15:0] rate;
	} mscl_row_t;
	logic                   REF_CLK;
	logic                   RST;
	logic                   PSEL;
	logic                   PENABLE;
	logic                   PWRITE;
	logic                   wt_go;
	logic                   fast;
	logic                   slv;
	logic [7:0]             PADDR;
	logic [31:0]            PWDATA;
	logic [31:0]            CUR_POS;
	logic [31:0]            rd_val;
	logic [31:0]            PRDATA;
	logic [31:0]            POS_VALUE;
	logic [31:0]            rx;
	logic                   PREADY;
	logic                   PSLVERR;
	logic                   POS_LOAD;
	logic                   TX_VALID;
	logic                   TX_READY;
	logic [7:0]             GP_OUT;
	logic [7:0]             TX_DATA;
	logic [15:0]            last_rate;
	mscl_pkg::mscl_motion_t MOTION;
	mscl_pkg::mscl_stop_t   STOP;
	mscl_pkg::mscl_move_t   MOVE;
	mscl_row_t              rows [9];
	int                     bad_count;
	int                     checks;
	int                     nreq;
	int                     nld;
	int                     n0;
	mscl_core i_dut (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .MOTION, .CUR_POS, .STOP,
		.MOVE, .POS_LOAD, .POS_VALUE, .GP_OUT, .TX_VALID, .TX_DATA,
		.TX_READY);
	mscl_motion_model i_mot (.REF_CLK, .RST, .STOP, .MOVE, .TX_VALID,
		.TX_DATA, .MOTION, .TX_READY, .wt_go, .fast, .rx);
	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end
	// Sampled mid-cycle, clear of the launching edge
	always @(negedge REF_CLK) begin
		if (STOP.req === 1'b1) begin
			nreq++;
			last_rate = STOP.rate;
		end
		if (POS_LOAD === 1'b1)
			nld++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		// No cycle count assumed; only PREADY or the watchdog ends this wait
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rd_val = PRDATA;
		slv = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_val, e);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [1:0] p,
		input logic [2:0] x);
		apb(1'b1, 8'h00, {21'h0, x, 2'h0, p, op});
	endtask
	// A hang here is caught by the watchdog, which counts it
	task automatic waitb(input logic v);
		while (MOTION.busy !== v) @(posedge REF_CLK);
		repeat (3) @(posedge REF_CLK);
	endtask
	task automatic wait_tx;
		repeat (2) @(posedge REF_CLK);
		while (TX_VALID !== 1'b0) @(posedge REF_CLK);
		@(posedge REF_CLK);
	endtask
	task automatic print_verdict;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge REF_CLK);
		bad_count++;
		print_verdict;
	end
	initial begin
		{RST, PSEL, PENABLE, PWRITE, wt_go, fast} = 6'b100000;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		CUR_POS = 32'h7fffffff;
		rows = '{'{0, 7, 1, 0, 1, 'h11}, '{1, 8, 1, 0, 0, 0},
			'{0, 8, 2, 1, 1, 'h44}, '{0, 7, 2, 1, 1, 'h11},
			'{0, 7, 2, 0, 1, 'h33}, '{1, 8, 3, 1, 1, 'h44},
			'{1, 7, 3, 1, 1, 'h22}, '{1, 7, 3, 2, 1, 'h33},
			'{1, 9, 3, 2, 0, 0}};
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h08 + 8'(4 * i), 32'h11 * (i + 1));
			rdc(8'h08 + 8'(4 * i), 32'h11 * (i + 1));
		end
		foreach (rows[i]) begin
			apb(1'b1, 8'h18, {31'h0, rows[i].mt});
			cmd(rows[i].mv, 2'h0, 3'h0);
			waitb(1'b1);
			n0 = nreq;
			cmd(rows[i].st, rows[i].prm, 3'h0);
			repeat (2) @(posedge REF_CLK);
			chk(32'(nreq - n0), 32'(rows[i].req));
			if (rows[i].req)
				chk(last_rate, rows[i].rate);
			waitb(1'b0);
		end
		wt_go <= 1'b1;
		@(posedge REF_CLK);
		wt_go <= 1'b0;
		cmd(4'h3, 2'h2, 3'h0);
		repeat (2) @(posedge REF_CLK);
		chk(MOTION.waiting, 1'b1);
		cmd(4'h2, 2'h0, 3'h0);
		// Abort pulse lands one edge later, the model clears one after
		repeat (2) @(posedge REF_CLK);
		chk(MOTION.waiting, 1'b0);
		// Without multitasking the queued stop must sit out the move
		apb(1'b1, 8'h18, 32'h0);
		cmd(4'h8, 2'h0, 3'h0);
		waitb(1'b1);
		n0 = nreq;
		cmd(4'h3, 2'h2, 3'h0);
		// Outputs taken as general purpose already
		cmd(4'h4, 2'h0, 3'h2);
		rdc(8'h1c, 32'h2);
		chk(32'(nreq - n0), 32'h0);
		waitb(1'b0);
		chk(GP_OUT, 8'hfb);
		cmd(4'h4, 2'h3, 3'h2);
		cmd(4'h8, 2'h0, 3'h0);
		waitb(1'b1);
		cmd(4'h4, 2'h0, 3'h1);
		cmd(4'h2, 2'h0, 3'h0);
		rdc(8'h1c, 32'h0);
		waitb(1'b0);
		chk(GP_OUT, 8'hff);
		apb(1'b1, 8'h04, 32'h656e6f64);
		cmd(4'h6, 2'h0, 3'h4);
		wait_tx;
		chk(rx, 32'h656e6f64);
		fast <= 1'b1;
		apb(1'b1, 8'h04, 32'h00004241);
		cmd(4'h6, 2'h0, 3'h2);
		wait_tx;
		chk(rx, 32'h4241656e);
		apb(1'b1, 8'h18, 32'h2);
		cmd(4'h6, 2'h0, 3'h4);
		repeat (2) @(posedge REF_CLK);
		chk(TX_VALID, 1'b0);
		// Encoder position would be sent just before this
		apb(1'b1, 8'h04, 32'h80000001);
		n0 = nld;
		cmd(4'h5, 2'h0, 3'h0);
		// Executes the cycle after queueing; the load pulse follows
		repeat (2) @(posedge REF_CLK);
		chk(POS_VALUE, 32'h80000001);
		chk(32'(nld - n0), 32'h1);
		cmd(4'h5, 2'h3, 3'h0);
		rdc(8'h20, 32'h7fffffff);
		RST <= 1'b1;
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		for (int i = 0; i < 4; i++)
			rdc(8'h08 + 8'(4 * i), 32'h64);
		rdc(8'h18, 32'h0);
		rdc(8'h28, 32'h0);
		chk(slv, 1'b1);
		chk(GP_OUT, 8'hff);
		print_verdict;
	end
endmodule

// >>> common/mscl_defs.svh
// Purpose: Constants for the motion stop command logic
// Assumes: APB byte addresses, 32-bit data
// Notes:   Opcodes and field ranges of the command word live here
`ifndef MSCL_DEFS_SVH
`define MSCL_DEFS_SVH

// Register byte offsets
`define MSCL_ADDR_CMD        8'h00
`define MSCL_ADDR_DATA       8'h04
`define MSCL_ADDR_JOG_ACCEL  8'h08
`define MSCL_ADDR_JOG_STOP   8'h0c
`define MSCL_ADDR_MAX_ACCEL  8'h10
`define MSCL_ADDR_FEED_DECEL 8'h14
`define MSCL_ADDR_CTRL       8'h18
`define MSCL_ADDR_STATUS     8'h1c
`define MSCL_ADDR_REPLY      8'h20
`define MSCL_ADDR_OUTS       8'h24

// Command word fields and control register bits
`define MSCL_CMD_OP          3:0
`define MSCL_CMD_PRM         5:4
`define MSCL_CMD_IDX         10:8
`define MSCL_CTRL_MULTITASK  0
`define MSCL_CTRL_HALF_DUPLX 1

// Opcodes
`define MSCL_OP_STOP_JOG     4'h1
`define MSCL_OP_STOP_FLUSH   4'h2
`define MSCL_OP_STOP_MOTION  4'h3
`define MSCL_OP_SET_OUTPUT   4'h4
`define MSCL_OP_SET_POSITION 4'h5
`define MSCL_OP_SEND_STRING  4'h6
`define MSCL_OP_COMMENCE_JOG 4'h7
`define MSCL_OP_FEED         4'h8
`define MSCL_OP_SEEK_HOME    4'h9

// Parameter letters
`define MSCL_PRM_NONE        2'h0
`define MSCL_PRM_D           2'h1
`define MSCL_PRM_M           2'h2
`define MSCL_PRM_HIGH        2'h3

// Move kinds
`define MSCL_KIND_FEED       2'h0
`define MSCL_KIND_JOG        2'h1
`define MSCL_KIND_HOME       2'h2

// Reset values and sizes
`define MSCL_RST_RATE        16'h0064
`define MSCL_RST_CTRL        2'h0
`define MSCL_RST_OUTS        8'hff
`define MSCL_QDEPTH          8
`define MSCL_STR_MAX         3'h4

`endif

// >>> common/mscl_pkg.sv
// Purpose: Types shared by the motion stop command logic
// Assumes: Constants come from mscl_defs.svh
// Notes:   Structs carry grouped signals across ports
package mscl_pkg;

	typedef struct packed {
		logic [3:0]  op;
		logic [1:0]  prm;
		logic [2:0]  idx;
		logic [31:0] arg;
	} mscl_cmd_t;

	typedef struct packed {
		logic       busy;
		logic [1:0] kind;
		logic       waiting;
	} mscl_motion_t;

	typedef struct packed {
		logic        req;
		logic [15:0] rate;
		logic        abort_wait;
	} mscl_stop_t;

	typedef struct packed {
		logic        start;
		logic [1:0]  kind;
		logic [31:0] arg;
	} mscl_move_t;

endpackage

// >>> logic/mscl_core.sv
// Purpose: Stop, output, position and string commands of a drive
// Assumes: One 10 MHz clock, synchronous active-high reset, APB slave
// Notes:   Motion unit raises busy the cycle after a move start
`timescale 1ns/1ns
`include "mscl_defs.svh"

module mscl_core (
	// Clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RST,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// Motion unit
	input  wire mscl_pkg::mscl_motion_t MOTION,
	input  wire logic [31:0]          CUR_POS,
	output mscl_pkg::mscl_stop_t      STOP,
	output mscl_pkg::mscl_move_t      MOVE,
	output logic                      POS_LOAD,
	output logic      [31:0]          POS_VALUE,
	// General-purpose outputs, 1 means open
	output logic      [7:0]           GP_OUT,
	// Serial transmit byte stream
	output logic                      TX_VALID,
	output logic      [7:0]           TX_DATA,
	input  wire logic                 TX_READY
);

	// Register index decode, shared by read and write paths
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		unique case (a)
			`MSCL_ADDR_CMD:        reg_sel = 4'h0;
			`MSCL_ADDR_DATA:       reg_sel = 4'h1;
			`MSCL_ADDR_JOG_ACCEL:  reg_sel = 4'h2;
			`MSCL_ADDR_JOG_STOP:   reg_sel = 4'h3;
			`MSCL_ADDR_MAX_ACCEL:  reg_sel = 4'h4;
			`MSCL_ADDR_FEED_DECEL: reg_sel = 4'h5;
			`MSCL_ADDR_CTRL:       reg_sel = 4'h6;
			`MSCL_ADDR_STATUS:     reg_sel = 4'h7;
			`MSCL_ADDR_REPLY:      reg_sel = 4'h8;
			`MSCL_ADDR_OUTS:       reg_sel = 4'h9;
			default:               reg_sel = 4'hf;
		endcase
	endfunction

	// Deceleration source: D picks feed or jog rate, else max
	function automatic logic [15:0] pick_rate(
		input logic [1:0]  prm,
		input logic [1:0]  kind,
		input logic [15:0] jog_rate,
		input logic [15:0] feed_rate,
		input logic [15:0] max_rate);
		if (prm == `MSCL_PRM_D) begin
			pick_rate = (kind == `MSCL_KIND_JOG) ? jog_rate : feed_rate;
		end else begin
			pick_rate = max_rate;
		end
	endfunction

	// Settings and state
	logic [31:0]             data_arg;
	logic [15:0]             jog_accel_setting;
	logic [15:0]             jog_stop_rate;
	logic [15:0]             max_accel_setting;
	logic [15:0]             feed_slowdown_rate;
	logic [1:0]              ctrl;
	logic [31:0]             reply_val;
	logic [3:0]              reply_tag;
	logic                    reply_valid;
	logic                    start_guard;
	logic [31:0]             tx_buf;
	logic [2:0]              tx_left;

	// Command queue
	mscl_pkg::mscl_cmd_t     q_mem [`MSCL_QDEPTH];
	logic [2:0]              wr_ptr;
	logic [2:0]              rd_ptr;
	logic [3:0]              q_count;

	// Bus decode
	logic [3:0]              wsel;
	logic                    acc;
	logic                    bad_addr;
	logic                    wr_en;
	logic                    rd_en;
	logic [31:0]             rdata;
	mscl_pkg::mscl_cmd_t     new_cmd;
	mscl_pkg::mscl_cmd_t     head;
	logic                    cmd_wr;
	logic                    imm_jog;
	logic                    imm_flush;
	logic                    q_full;
	logic                    enq;
	logic                    multitask;
	logic                    half_duplex;
	logic                    exec_ready;
	logic                    exec_go;
	logic                    x_stop_motion;
	logic                    x_set_output;
	logic                    x_set_pos;
	logic                    x_send;
	logic                    x_move;
	logic                    is_jogging;
	logic [2:0]              str_len;
	logic [3:0]              next_count;

	assign wsel        = reg_sel(PADDR);
	assign acc         = PSEL & PENABLE;
	assign bad_addr    = (wsel == 4'hf) | (PADDR[1:0] != 2'h0);
	assign wr_en       = acc & PWRITE & ~bad_addr;
	assign rd_en       = PSEL & ~PENABLE & ~PWRITE;
	assign multitask   = ctrl[`MSCL_CTRL_MULTITASK];
	assign half_duplex = ctrl[`MSCL_CTRL_HALF_DUPLX];

	assign new_cmd.op  = PWDATA[`MSCL_CMD_OP];
	assign new_cmd.prm = PWDATA[`MSCL_CMD_PRM];
	assign new_cmd.idx = PWDATA[`MSCL_CMD_IDX];
	assign new_cmd.arg = data_arg;

	assign cmd_wr      = wr_en & (wsel == 4'h0);
	assign imm_jog     = cmd_wr & (new_cmd.op == `MSCL_OP_STOP_JOG);
	assign imm_flush   = cmd_wr & (new_cmd.op == `MSCL_OP_STOP_FLUSH);
	assign q_full      = (q_count == 4'(`MSCL_QDEPTH));
	assign enq         = cmd_wr & ~imm_jog & ~imm_flush & ~q_full;

	// A buffered command refused for a full queue reports an error
	assign PREADY      = 1'b1;
	assign PSLVERR     = acc & (bad_addr | (cmd_wr & q_full & ~imm_jog
	                     & ~imm_flush));

	// Executor: without multitasking a move or wait holds the queue
	assign head        = q_mem[rd_ptr];
	assign exec_ready  = (tx_left == 3'h0) & ~start_guard
	                     & (multitask | ~(MOTION.busy | MOTION.waiting));
	assign exec_go     = (q_count != 4'h0) & exec_ready & ~imm_flush;
	assign x_stop_motion = exec_go & (head.op == `MSCL_OP_STOP_MOTION);
	assign x_set_output  = exec_go & (head.op == `MSCL_OP_SET_OUTPUT);
	assign x_set_pos     = exec_go & (head.op == `MSCL_OP_SET_POSITION);
	assign x_send        = exec_go & (head.op == `MSCL_OP_SEND_STRING);
	assign x_move        = exec_go & ((head.op == `MSCL_OP_COMMENCE_JOG)
	                       | (head.op == `MSCL_OP_FEED)
	                       | (head.op == `MSCL_OP_SEEK_HOME));
	assign is_jogging    = MOTION.busy & (MOTION.kind == `MSCL_KIND_JOG);
	assign str_len       = ((head.idx == 3'h0) | (head.idx > `MSCL_STR_MAX))
	                       ? `MSCL_STR_MAX : head.idx;

	// Only stop-flush empties the queue; stop-motion never touches it
	assign next_count = imm_flush ? 4'h0 :
	                    4'(q_count + {3'h0, enq} - {3'h0, exec_go});

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wr_ptr  <= 3'h0;
			rd_ptr  <= 3'h0;
			q_count <= 4'h0;
		end else begin
			q_count <= next_count;
			if (imm_flush) begin
				wr_ptr <= 3'h0;
				rd_ptr <= 3'h0;
			end else begin
				wr_ptr <= enq ? 3'(wr_ptr + 3'h1) : wr_ptr;
				rd_ptr <= exec_go ? 3'(rd_ptr + 3'h1) : rd_ptr;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (enq) begin
			q_mem[wr_ptr] <= new_cmd;
		end
	end

	// Software settings
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			data_arg           <= 32'h0;
			jog_accel_setting  <= `MSCL_RST_RATE;
			jog_stop_rate      <= `MSCL_RST_RATE;
			max_accel_setting  <= `MSCL_RST_RATE;
			feed_slowdown_rate <= `MSCL_RST_RATE;
			ctrl               <= `MSCL_RST_CTRL;
		end else if (wr_en) begin
			unique case (wsel)
				4'h1:    data_arg           <= PWDATA;
				4'h2:    jog_accel_setting  <= PWDATA[15:0];
				4'h3:    jog_stop_rate      <= PWDATA[15:0];
				4'h4:    max_accel_setting  <= PWDATA[15:0];
				4'h5:    feed_slowdown_rate <= PWDATA[15:0];
				4'h6:    ctrl               <= PWDATA[1:0];
				default: ctrl               <= ctrl;
			endcase
		end
	end

	// Stop requests: flush beats stop-jog beats a queued stop-motion
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			STOP <= '0;
		end else begin
			STOP.req        <= 1'b0;
			STOP.abort_wait <= 1'b0;
			if (imm_flush) begin
				STOP.req        <= MOTION.busy;
				STOP.abort_wait <= MOTION.waiting;
				STOP.rate       <= pick_rate(new_cmd.prm, MOTION.kind,
				                   jog_accel_setting, feed_slowdown_rate,
				                   max_accel_setting);
			end else if (imm_jog & is_jogging) begin
				STOP.req  <= 1'b1;
				STOP.rate <= jog_accel_setting;
			end else if (x_stop_motion & MOTION.busy
			             & (MOTION.kind != `MSCL_KIND_HOME)) begin
				STOP.req  <= 1'b1;
				STOP.rate <= pick_rate(head.prm, MOTION.kind,
				             jog_stop_rate, feed_slowdown_rate,
				             max_accel_setting);
			end
		end
	end

	// Move starts; the guard covers the cycle before busy rises
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			MOVE        <= '0;
			start_guard <= 1'b0;
		end else begin
			MOVE.start  <= x_move;
			start_guard <= x_move;
			if (x_move) begin
				MOVE.arg  <= head.arg;
				MOVE.kind <= (head.op == `MSCL_OP_COMMENCE_JOG)
				             ? `MSCL_KIND_JOG
				             : (head.op == `MSCL_OP_SEEK_HOME)
				             ? `MSCL_KIND_HOME : `MSCL_KIND_FEED;
			end
		end
	end

	// Output pins, one flop each
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gp_bit
			always_ff @(posedge REF_CLK) begin
				if (RST) begin
					GP_OUT[g] <= 1'(`MSCL_RST_OUTS >> g);
				end else if (x_set_output & (head.idx == 3'(g))) begin
					GP_OUT[g] <= (head.prm == `MSCL_PRM_HIGH);
				end
			end
		end
	endgenerate

	// Position load or report; a new reply wins over the read clear
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			POS_LOAD    <= 1'b0;
			POS_VALUE   <= 32'h0;
			reply_val   <= 32'h0;
			reply_tag   <= 4'h0;
			reply_valid <= 1'b0;
		end else begin
			POS_LOAD <= x_set_pos & (head.prm != `MSCL_PRM_HIGH);
			if (x_set_pos & (head.prm != `MSCL_PRM_HIGH)) begin
				POS_VALUE <= head.arg;
			end
			if (x_set_pos & (head.prm == `MSCL_PRM_HIGH)) begin
				reply_val   <= CUR_POS;
				reply_tag   <= head.op;
				reply_valid <= 1'b1;
			end else if (acc & ~PWRITE & (wsel == 4'h8)) begin
				reply_valid <= 1'b0;
			end
		end
	end

	// String echo, low byte first; flush cuts it short
	assign TX_VALID = (tx_left != 3'h0);
	assign TX_DATA  = tx_buf[7:0];

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tx_buf  <= 32'h0;
			tx_left <= 3'h0;
		end else if (imm_flush) begin
			tx_left <= 3'h0;
		end else if (x_send & ~half_duplex) begin
			tx_buf  <= head.arg;
			tx_left <= str_len;
		end else if (TX_VALID & TX_READY) begin
			tx_buf  <= {8'h0, tx_buf[31:8]};
			tx_left <= 3'(tx_left - 3'h1);
		end
	end

	// Read data captured in the setup phase
	always_comb begin
		unique case (wsel)
			4'h1:    rdata = data_arg;
			4'h2:    rdata = {16'h0, jog_accel_setting};
			4'h3:    rdata = {16'h0, jog_stop_rate};
			4'h4:    rdata = {16'h0, max_accel_setting};
			4'h5:    rdata = {16'h0, feed_slowdown_rate};
			4'h6:    rdata = {30'h0, ctrl};
			4'h7:    rdata = {20'h0, reply_tag, reply_valid, TX_VALID,
			                  q_full, 1'b0, q_count};
			4'h8:    rdata = reply_val;
			4'h9:    rdata = {24'h0, GP_OUT};
			default: rdata = 32'h0;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PRDATA <= 32'h0;
		end else if (rd_en) begin
			PRDATA <= bad_addr ? 32'h0 : rdata;
		end
	end

endmodule
